// ===== hdl/sbl_loader.v
// bootstrap serial loader top with Avalon-MM register slave
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "sbl_regs.vh"
module sbl_loader (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        boot_mode_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        rxd_pin_i,
  output wire        txd_pin_o,
  output wire        txd_pin_oe_o,
  output wire        pins_owned_o,
  output wire        wire_or_o,
  output wire        reset_disable_o,
  output wire        priv_write_en_o,
  output wire        boot_rom_map_o,
  output reg         jump_o,
  output reg  [15:0] jump_addr_o,
  output reg  [15:0] stack_ptr_o
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_BREAK = 3'd1;
  localparam ST_FIRST = 3'd2;
  localparam ST_LOAD  = 3'd3;
  localparam ST_DONE  = 3'd4;
  localparam integer IDLE_FAST_TOP = `SBL_DIV_FAST - 1;
  localparam integer IDLE_SLOW_TOP = `SBL_DIV_SLOW - 1;

  reg        rs1_reg;
  reg        rst_n;
  reg  [2:0] state_reg;
  reg        mode_reg;
  reg  [7:0] ctrl_reg;
  reg        slow_reg;
  reg        tx_start_reg;
  reg  [9:0] count_reg;
  reg  [8:0] ramidx_reg;
  reg  [7:0] ram_q_reg;
  reg  [7:0] ram [0:`SBL_RAM_DEPTH-1];
  reg  [3:0] idle_ph_reg;
  reg  [3:0] idle_bit_reg;
  reg  [2:0] idle_chr_reg;
  reg  [11:0] idle_div_reg;
  reg        ack_reg;
  wire       rx_valid;
  wire [7:0] rx_data;
  wire       rx_brk;
  wire       tx_busy;
  wire       txd_low;
  wire       running = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
  wire       uart_en = mode_reg && (state_reg != ST_IDLE);
  wire       varlen  = ctrl_reg[`SBL_CTRL_VARLEN];
  wire [11:0] idle_top = slow_reg ? IDLE_SLOW_TOP[11:0] : IDLE_FAST_TOP[11:0];
  wire       idle_tick = (idle_div_reg == idle_top);
  wire       req = avs_read_i || avs_write_i;

  // reset release through two flip-flops
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end

  sbl_uart u_uart (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .en_i       (uart_en),
    .slow_i     (slow_reg),
    .rxd_i      (rxd_pin_i),
    .tx_start_i (tx_start_reg),
    .tx_brk_i   (state_reg == ST_BREAK),
    .tx_data_i  (rx_data),
    .tx_busy_o  (tx_busy),
    .txd_low_o  (txd_low),
    .rx_valid_o (rx_valid),
    .rx_data_o  (rx_data),
    .rx_brk_o   (rx_brk)
  );

  // pin ownership and special-mode controls
  assign pins_owned_o    = uart_en;
  assign txd_pin_o       = 1'b0;
  assign txd_pin_oe_o    = uart_en && txd_low;            // pull low only
  assign wire_or_o       = mode_reg;
  assign reset_disable_o = mode_reg && ctrl_reg[`SBL_CTRL_RESET_DISABLE_BIT];
  assign priv_write_en_o = mode_reg;
  assign boot_rom_map_o  = mode_reg && ctrl_reg[`SBL_CTRL_BOOTROM];
  assign avs_waitrequest_o = req && !ack_reg;

  // idle timer: four character times, armed after sync
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_div_reg <= 12'h000;
      idle_ph_reg  <= 4'h0;
      idle_bit_reg <= 4'h0;
      idle_chr_reg <= 3'd0;
    end else if (state_reg != ST_LOAD || rx_valid || !rxd_pin_i) begin
      idle_div_reg <= 12'h000;
      idle_ph_reg  <= 4'h0;
      idle_bit_reg <= 4'h0;
      idle_chr_reg <= 3'd0;
    end else if (idle_tick) begin
      idle_div_reg <= 12'h000;
      idle_ph_reg  <= idle_ph_reg + 4'h1;
      if (idle_ph_reg == 4'hF) begin
        idle_bit_reg <= (idle_bit_reg == 4'h9) ? 4'h0 : idle_bit_reg + 4'h1;
        if (idle_bit_reg == 4'h9 && idle_chr_reg != 3'd`SBL_IDLE_CHARS)
          idle_chr_reg <= idle_chr_reg + 3'd1;
      end
    end else begin
      idle_div_reg <= idle_div_reg + 12'h001;
    end
  end

  // loader sequence
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      mode_reg     <= 1'b0;
      slow_reg     <= 1'b0;
      tx_start_reg <= 1'b0;
      count_reg    <= 10'd0;
      jump_o       <= 1'b0;
      jump_addr_o  <= 16'h0000;
      stack_ptr_o  <= 16'h0000;
    end else begin
      tx_start_reg <= 1'b0;
      jump_o       <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          mode_reg <= boot_mode_i; // strap caught after release
          if (boot_mode_i) begin
            state_reg    <= ST_BREAK; // serial unit on, rx and tx
            tx_start_reg <= 1'b1;
          end else
            state_reg <= ST_DONE;
        end
        ST_BREAK: begin
          if (!tx_start_reg && !tx_busy)
            state_reg <= ST_FIRST; // break sent once
        end
        ST_FIRST: begin
          if (rx_valid) begin // waits forever for first char
            if (rx_brk || rx_data == 8'h00) begin
              jump_addr_o <= `SBL_EEPROM_ADDR;
              stack_ptr_o <= `SBL_RAM_TOP;
              jump_o      <= 1'b1;
              state_reg   <= ST_DONE;
            end else if (rx_data == `SBL_RAMJUMP_CHAR) begin
              jump_addr_o <= `SBL_RAM_BASE;
              stack_ptr_o <= `SBL_RAM_TOP;
              jump_o      <= 1'b1;
              state_reg   <= ST_DONE;
            end else begin
              slow_reg  <= (rx_data != `SBL_SYNC_CHAR); // baud from sync
              count_reg <= 10'd0;
              state_reg <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (rx_valid) begin
            count_reg    <= count_reg + 10'd1; // consecutive addresses
            tx_start_reg <= !tx_busy;          // echo for verify
          end
          if ((!varlen && rx_valid && count_reg == `SBL_FIXED_LEN - 10'd1)
              || (varlen && (count_reg == 10'd`SBL_RAM_DEPTH
                  || idle_chr_reg == 3'd`SBL_IDLE_CHARS))) begin
            jump_addr_o <= `SBL_RAM_BASE;
            stack_ptr_o <= `SBL_RAM_TOP;
            jump_o      <= 1'b1;
            state_reg   <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // program RAM written by loader, readable by software
  always @(posedge clk_i) begin
    if (state_reg == ST_LOAD && rx_valid && count_reg < 10'd`SBL_RAM_DEPTH)
      ram[count_reg[8:0]] <= rx_data;
    ram_q_reg <= ram[ramidx_reg];
  end

  // Avalon-MM slave: one wait state, answers on second edge
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg        <= 1'b0;
      ctrl_reg       <= `SBL_CTRL_RESET; // boot ROM, reset_disable_bit, varlen set
      ramidx_reg     <= 9'd0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      // write lands at the edge where waitrequest is seen low
      if (req && ack_reg) begin
        if (avs_write_i && avs_address_i == `SBL_ADDR_CTRL && mode_reg)
          ctrl_reg <= avs_writedata_i[7:0]; // privileged write
        if (avs_write_i && avs_address_i == `SBL_ADDR_RAMIDX)
          ramidx_reg <= avs_writedata_i[8:0];
      end
      if (req && !ack_reg) begin
        case (avs_address_i)
          `SBL_ADDR_CTRL:    avs_readdata_o <= {24'h0, ctrl_reg};
          `SBL_ADDR_STATUS:  avs_readdata_o <= {27'h0, mode_reg, running, state_reg == ST_DONE, slow_reg, jump_o};
          `SBL_ADDR_JUMP:    avs_readdata_o <= {16'h0, jump_addr_o};
          `SBL_ADDR_STACK:   avs_readdata_o <= {16'h0, stack_ptr_o};
          `SBL_ADDR_COUNT:   avs_readdata_o <= {22'h0, count_reg};
          `SBL_ADDR_RAMDATA: avs_readdata_o <= {24'h0, ram_q_reg};
          `SBL_ADDR_RAMIDX:  avs_readdata_o <= {23'h0, ramidx_reg};
          default:           avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ===== hdl/sbl_regs.vh
// constants for the serial bootstrap loader
//
// Overview of operation
// - serial unit initialised, receiver and transmitter enabled before accepting download bytes
// - serial unit owns receive and transmit port pins while loader runs
// - port outputs are open-drain; transmit only pulls low
// - stack pointer set to top of on-chip RAM before jumping
// - reset-disable bit set so watchdog and clock monitor cannot reset
// - privileged bits writable and write protection lifted in bootstrap mode
// - boot ROM mapped from reset and answers reads in bootstrap mode while its enable bit is set
// - first character zero or break jumps to start of EEPROM
// - start bit only on high-to-low edge; steady low line gives nothing
// - transmitter sends one break character when loader starts
// - host sends sync character first; loader picks baud rate from it
// - RAM-jump code at default rate jumps to start of RAM
// - sync then four idle character times jumps to start of RAM
// - fixed-length mode accepts exactly 256 bytes after sync, 257 total
// - variable-length mode ends after four idle character times
// - idle timeout armed only after sync; wait forever before it
// - boot-ROM enable resets to one and stays writable
`ifndef SBL_REGS_VH
`define SBL_REGS_VH
`define SBL_ADDR_CTRL      4'h0
`define SBL_ADDR_STATUS    4'h1
`define SBL_ADDR_JUMP      4'h2
`define SBL_ADDR_STACK     4'h3
`define SBL_ADDR_COUNT     4'h4
`define SBL_ADDR_RAMDATA   4'h5
`define SBL_ADDR_RAMIDX    4'h6
`define SBL_CTRL_RESET     8'h07
`define SBL_CTRL_VARLEN    0
`define SBL_CTRL_BOOTROM   1
`define SBL_CTRL_RESET_DISABLE_BIT      2
`define SBL_SYNC_CHAR      8'hFF
`define SBL_RAMJUMP_CHAR   8'h55
`define SBL_EEPROM_ADDR    16'hB600
`define SBL_RAM_BASE       16'h0000
`define SBL_RAM_TOP        16'h01FF
`define SBL_RAM_DEPTH      512
`define SBL_FIXED_LEN      10'd256
`define SBL_IDLE_CHARS     4
`define SBL_CLK_HZ         20000000
`define SBL_BAUD_FAST      7812
`define SBL_BAUD_SLOW      1200
`define SBL_DIV_FAST       (`SBL_CLK_HZ / (`SBL_BAUD_FAST * 16))
`define SBL_DIV_SLOW       (`SBL_CLK_HZ / (`SBL_BAUD_SLOW * 16))
`endif

// ===== hdl/sbl_uart.v
// serial unit: 8N1 receiver and open-drain transmitter with break
`timescale 1ns/1ns
`include "sbl_regs.vh"
module sbl_uart (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       en_i,
  input  wire       slow_i,
  input  wire       rxd_i,
  input  wire       tx_start_i,
  input  wire       tx_brk_i,
  input  wire [7:0] tx_data_i,
  output wire       tx_busy_o,
  output reg        txd_low_o,
  output reg        rx_valid_o,
  output reg  [7:0] rx_data_o,
  output reg        rx_brk_o
);
  localparam integer DIV_FAST_TOP = `SBL_DIV_FAST - 1;
  localparam integer DIV_SLOW_TOP = `SBL_DIV_SLOW - 1;
  reg  [11:0] div_reg;
  wire [11:0] div_top = slow_i ? DIV_SLOW_TOP[11:0] : DIV_FAST_TOP[11:0];
  wire        tick = (div_reg == div_top);
  reg         rx_prev_reg;
  reg         rx_act_reg;
  reg  [3:0]  rx_ph_reg;
  reg  [3:0]  rx_bit_reg;
  reg  [7:0]  rx_sh_reg;
  reg         tx_act_reg;
  reg  [3:0]  tx_ph_reg;
  reg  [3:0]  tx_bit_reg;
  reg  [9:0]  tx_sh_reg;

  assign tx_busy_o = tx_act_reg;

  // 16x oversample tick divider
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      div_reg <= 12'h000;
    else if (tick || !en_i)
      div_reg <= 12'h000;
    else
      div_reg <= div_reg + 12'h001;
  end

  // receiver: start only on falling edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_prev_reg <= 1'b0; // line must be seen high before a start
      rx_act_reg  <= 1'b0;
      rx_ph_reg   <= 4'h0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      rx_valid_o  <= 1'b0;
      rx_data_o   <= 8'h00;
      rx_brk_o    <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (tick) begin
        rx_prev_reg <= rxd_i;
        if (!rx_act_reg) begin
          if (en_i && rx_prev_reg && !rxd_i) begin // 1-to-0 only
            rx_act_reg <= 1'b1;
            rx_ph_reg  <= 4'h0;
            rx_bit_reg <= 4'h0;
          end
        end else begin
          rx_ph_reg <= rx_ph_reg + 4'h1;
          if (rx_ph_reg == 4'h7) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h8)
              rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]};
            if (rx_bit_reg == 4'h9) begin
              rx_act_reg <= 1'b0;
              rx_valid_o <= 1'b1;
              rx_data_o  <= rx_sh_reg;
              rx_brk_o   <= !rxd_i && (rx_sh_reg == 8'h00);
            end
          end
        end
      end
    end
  end

  // transmitter: data frame or all-zero break frame
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_act_reg <= 1'b0;
      tx_ph_reg  <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 10'h3FF;
      txd_low_o  <= 1'b0;
    end else if (!tx_act_reg) begin
      txd_low_o <= 1'b0;
      if (tx_start_i && en_i) begin
        tx_act_reg <= 1'b1;
        tx_ph_reg  <= 4'h0;
        tx_bit_reg <= 4'h0;
        tx_sh_reg  <= tx_brk_i ? 10'h000 : {1'b1, tx_data_i, 1'b0};
      end
    end else if (tick && tx_bit_reg == 4'hA) begin
      tx_act_reg <= 1'b0; // tenth bit has run its full time
      txd_low_o  <= 1'b0;
    end else if (tick) begin
      txd_low_o <= !tx_sh_reg[0]; // open drain: only pulls low
      tx_ph_reg <= tx_ph_reg + 4'h1;
      if (tx_ph_reg == 4'hF) begin
        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
      end
    end
  end
endmodule

// ===== testbench/sbl_loader_assertions.sv
// port checker for the bootstrap loader
`timescale 1ns/1ns
module sbl_loader_chk (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        txd_pin_o,
  input wire logic        txd_pin_oe_o,
  input wire logic        pins_owned_o,
  input wire logic        wire_or_o,
  input wire logic        reset_disable_o,
  input wire logic        priv_write_en_o,
  input wire logic        boot_rom_map_o,
  input wire logic        jump_o,
  input wire logic [15:0] jump_addr_o,
  input wire logic [15:0] stack_ptr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // bus request held in its wait state, then answered
  sequence req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence req_done;
    !avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (req_wait |=> req_done) else $error("bus answer late");
  od_drive_a: assert property (txd_pin_oe_o |-> !txd_pin_o && pins_owned_o)
    else $error("transmit pin driven high or not owned");
  own_mode_a: assert property (pins_owned_o |-> wire_or_o && priv_write_en_o)
    else $error("pins owned outside bootstrap setup");
  reset_disable_bit_mode_a: assert property (reset_disable_o |-> wire_or_o)
    else $error("reset disable outside bootstrap");
  rom_mode_a: assert property (boot_rom_map_o |-> priv_write_en_o)
    else $error("boot rom mapped outside bootstrap");
  jump_pulse_a: assert property (jump_o |=> !jump_o)
    else $error("jump pulse too long");
  jump_target_a: assert property (jump_o |=> jump_addr_o == 16'hB600 || jump_addr_o == 16'h0000)
    else $error("jump target wrong");
  stack_top_a: assert property (jump_o |=> stack_ptr_o == 16'h01FF)
    else $error("stack pointer not at ram top");
  jump_hold_a: assert property (jump_o ##1 1'b1 |=> $stable(jump_addr_o)[*4])
    else $error("jump address not held");
endmodule
bind sbl_loader sbl_loader_chk i_sbl_loader_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .txd_pin_o(txd_pin_o), .txd_pin_oe_o(txd_pin_oe_o),
  .pins_owned_o(pins_owned_o), .wire_or_o(wire_or_o), .reset_disable_o(reset_disable_o),
  .priv_write_en_o(priv_write_en_o), .boot_rom_map_o(boot_rom_map_o), .jump_o(jump_o),
  .jump_addr_o(jump_addr_o), .stack_ptr_o(stack_ptr_o)
);

// ===== testbench/sbl_host_model.sv
// host side of the serial link
`timescale 1ns/1ns
module sbl_host_model #(
  parameter integer BIT = 2560
) (
  input  wire logic clk_i,
  input  wire logic txd_line_i,
  output logic      rxd_o
);
  integer run = 0;
  integer longest = 0;
  integer lows = 0;
  initial rxd_o = 1'b1;
  // time low stretches on the pulled-up transmit line
  always @(posedge clk_i) begin
    if (!txd_line_i) run <= run + 1;
    else if (run > 0) begin
      lows <= lows + 1;
      if (run > longest) longest <= run;
      run <= 0;
    end
  end
  // drive the receive line for n bit times
  task drive(input logic v, input integer n);
    begin
      rxd_o <= v;
      repeat (n * BIT) @(posedge clk_i);
    end
  endtask
  // start bit and data lsb first; idle high serves as stop
  task send_byte(input logic [7:0] b);
    integer i;
    begin
      drive(1'b0, 1);
      for (i = 0; i < 8; i = i + 1) drive(b[i], 1);
      rxd_o <= 1'b1;
    end
  endtask
endmodule

// ===== testbench/tb_sbl_loader.sv
// self-checking bench for the bootstrap loader
`timescale 1ns/1ns
`include "sbl_regs.vh"
module tb_sbl_loader;
  localparam integer BIT = 16 * `SBL_DIV_FAST;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        boot_mode_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] rd;
  logic [31:0] keep;
  wire  [31:0] avs_readdata_o;
  wire  [15:0] jump_addr_o, stack_ptr_o;
  wire         avs_waitrequest_o, rxd_pin_i, txd_pin_o, txd_pin_oe_o, pins_owned_o, wire_or_o;
  wire         reset_disable_o, priv_write_en_o, boot_rom_map_o, jump_o;
  wire         txd_line = txd_pin_oe_o ? txd_pin_o : 1'b1;
  integer      err_total = 0;
  integer      compares = 0;
  sbl_loader i_sbl_loader (.clk_i(clk_i), .nrst_i(nrst_i), .boot_mode_i(boot_mode_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rxd_pin_i(rxd_pin_i), .txd_pin_o(txd_pin_o),
    .txd_pin_oe_o(txd_pin_oe_o), .pins_owned_o(pins_owned_o), .wire_or_o(wire_or_o),
    .reset_disable_o(reset_disable_o), .priv_write_en_o(priv_write_en_o),
    .boot_rom_map_o(boot_rom_map_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o),
    .stack_ptr_o(stack_ptr_o));
  sbl_host_model #(.BIT(BIT)) i_host (.clk_i(clk_i), .txd_line_i(txd_line), .rxd_o(rxd_pin_i));
  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task report_and_stop;
    begin
      $display("compares=%0d errors=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task bail;
    begin
      err_total = err_total + 1;
      $display("[FAIL] t=%0t wait limit reached", $time);
      report_and_stop();
    end
  endtask
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk1(input logic got, input logic exp);
    begin
      chk32({31'h0, got}, {31'h0, exp});
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      k = 0;
      @(negedge clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
        k = k + 1;
        if (k > 50) bail();
        @(negedge clk_i);
      end
      @(posedge clk_i);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(negedge clk_i);
    end
  endtask
  task do_reset(input logic mode);
    begin
      @(posedge clk_i);
      nrst_i <= 1'b0;
      boot_mode_i <= mode;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask
  task wait_until(input integer lim, input integer kind);
    integer k;
    begin
      k = 0;
      while (kind == 0 ? jump_o !== 1'b1 : i_host.lows < kind) begin
        k = k + 1;
        if (k > lim) bail();
        @(negedge clk_i);
      end
    end
  endtask
  task t_normal;
    begin
      do_reset(1'b0);
      chk1(pins_owned_o, 1'b0);
      chk1(reset_disable_o, 1'b0);
      bus(1'b0, 4'h0, 32'h0);
      keep = rd;
      bus(1'b1, 4'h0, keep ^ 32'h6);
      bus(1'b0, 4'h0, 32'h0);
      chk32(rd, keep);
      $display("normal mode test done");
    end
  endtask
  task t_boot_regs;
    begin
      do_reset(1'b1);
      chk1(wire_or_o, 1'b1);
      chk1(pins_owned_o, 1'b1);
      chk1(reset_disable_o, 1'b1);
      chk1(priv_write_en_o, 1'b1);
      chk1(boot_rom_map_o, 1'b1);
      bus(1'b0, 4'h0, 32'h0);
      chk32(rd & 32'h6, 32'h6);
      bus(1'b1, 4'h0, rd & 32'h5);
      chk1(boot_rom_map_o, 1'b0);
      bus(1'b0, 4'h0, 32'h0);
      chk32(rd & 32'h6, 32'h4);
      bus(1'b1, 4'h0, rd | 32'h2);
      chk1(boot_rom_map_o, 1'b1);
      bus(1'b0, 4'hF, 32'h0);
      chk32(rd, 32'h0);
      $display("bootstrap register test done");
    end
  endtask
  task t_break_eeprom;
    begin
      wait_until(30000, 1);
      chk1(i_host.longest >= 10 * BIT - 16 && i_host.longest <= 10 * BIT + 16, 1'b1);
      @(posedge clk_i);
      i_host.send_byte(8'h00);
      wait_until(2 * BIT, 0);
      chk32({16'h0, jump_addr_o}, 32'hB600);
      chk32({16'h0, stack_ptr_o}, 32'h01FF);
      chk1(i_host.lows == 1, 1'b1);
      bus(1'b0, 4'h2, 32'h0);
      chk32(rd & 32'hFFFF, 32'hB600);
      $display("break and eeprom jump test done");
    end
  endtask
  task t_low_ramjump;
    begin
      @(posedge clk_i);
      i_host.drive(1'b0, 0);
      do_reset(1'b1);
      wait_until(30000, 2);
      chk1(jump_o, 1'b0);
      bus(1'b0, 4'h1, 32'h0);
      chk32(rd, 32'h18);
      @(posedge clk_i);
      i_host.drive(1'b1, 1);
      i_host.send_byte(8'h55);
      wait_until(2 * BIT, 0);
      chk32({16'h0, jump_addr_o}, 32'h0000);
      chk32({16'h0, stack_ptr_o}, 32'h01FF);
      $display("held low and ram jump test done");
    end
  endtask
  initial begin
    t_normal();
    t_boot_regs();
    t_break_eeprom();
    t_low_ramjump();
    report_and_stop();
  end
endmodule
